// [ext_bus_write_pkg.sv]
package ext_bus_write_pkg;

  // Widths of the external parallel bus, the timing fields and the counters.
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 3;
  localparam int CNT_W = 16;

  // Byte addresses of the software registers.
  localparam logic [31:0] ZONE_TIMING_CONFIG_OFS = 32'h0000_0000;
  localparam logic [31:0] WRITE_ADDR_OFS = 32'h0000_0004;
  localparam logic [31:0] WRITE_DATA_OFS = 32'h0000_0008;
  localparam logic [31:0] STATUS_OFS = 32'h0000_000c;

  // Field positions inside the timing configuration register.
  localparam int LEAD_POS = 0;
  localparam int ACTIVE_POS = 3;
  localparam int TRAIL_POS = 6;
  localparam int READY_EN_POS = 9;
  localparam int READY_MODE_POS = 10;

  // Field positions inside the status register.
  localparam int BUSY_POS = 0;
  localparam int WAIT_POS = 16;

  // Values after reset of the timing configuration.
  localparam logic [FIELD_W-1:0] LEAD_RESET = 3'h1;
  localparam logic [FIELD_W-1:0] ACTIVE_RESET = 3'h3;
  localparam logic [FIELD_W-1:0] TRAIL_RESET = 3'h1;
  localparam logic READY_EN_RESET = 1'b0;
  localparam logic READY_MODE_RESET = 1'b0;

  // Encodings of the sampling style bit.
  localparam logic READY_SYNC = 1'b0;
  localparam logic READY_ASYNC = 1'b1;

  // Periods by which the asynchronous first sample comes early.
  localparam logic [CNT_W-1:0] ASYNC_EARLY_CYCLES = 16'h0002;

  // AXI4-Lite response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Phases of one external write access.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ALIGN,
    PH_LEAD,
    PH_ACTIVE,
    PH_TRAIL
  } phase_t;

endpackage : ext_bus_write_pkg

// [bit_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

// Two flip-flop synchroniser for one level.
module bit_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1; // First stage, read only by the second stage.
    logic s2; // Second stage, safe to use.
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Shift the input through both stages.
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Register the stages, clearing them in reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule : bit_sync2

`default_nettype wire

// [toggle_event.sv]
`timescale 1ns/1ps
`default_nettype none

// Turns a toggle from another domain into a one-cycle pulse.
module toggle_event (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tgl_in,
  output logic      pulse
);

  typedef struct packed {
    logic s1;   // First stage, read only by the second stage.
    logic s2;   // Synchronised toggle.
    logic last; // Toggle value seen one cycle before.
  } tgl_state_t;

  tgl_state_t st;
  tgl_state_t next_st;

  // Shift the toggle and keep its previous value.
  always_comb begin
    next_st.s1 = tgl_in;
    next_st.s2 = st.s1;
    next_st.last = st.s2;
  end

  // Register the stages, clearing them in reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // A change of the synchronised toggle is one event.
  assign pulse = st.s2 ^ st.last;

endmodule : toggle_event

`default_nettype wire

// [ext_bus_write_ready_wait.sv]
// Behaviour
// - Synchronous first ready sample at lead plus active.
// - Asynchronous first sample two periods earlier.
// - Synchronous: high completes, low resamples each period.
// - Asynchronous: low stalls, resample until high.
// - Lead starts on output clock rise; align.
// - Alignment cycle keeps all strobes inactive.
// - Address bus holds last value when inactive.
// - Data drive starts with write strobe assertion.
// - Write data held through the trail phase.
// - Data released when read-not-write returns high.
`timescale 1ns/1ps
`default_nettype none

module ext_bus_write_ready_wait
  import ext_bus_write_pkg::*;
(
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [31:0]                         s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [31:0]                         s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  input  wire logic                                iface_timing_clock,
  input  wire logic                                ext_ready_in,
  output logic                                     iface_clock_out,
  output logic                                     zone_select_n,
  output logic                                     write_strobe_n,
  output logic                                     read_not_write,
  output logic [ext_bus_write_pkg::ADDR_W-1:0]     addr_out,
  output logic [ext_bus_write_pkg::DATA_W-1:0]     data_out,
  output logic                                     data_oe
);

  import ext_bus_write_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register side state, clocked by aclk.

  typedef struct packed {
    logic                  aw_full;   // Write address is held.
    logic [31:0]           aw_addr;   // Held write address.
    logic                  w_full;    // Write data is held.
    logic [31:0]           w_data;    // Held write data.
    logic [3:0]            w_strb;    // Held byte enables.
    logic                  awready;   // Write address ready.
    logic                  wready;    // Write data ready.
    logic                  bvalid;    // Write response valid.
    logic [1:0]            bresp;     // Write response code.
    logic                  arready;   // Read address ready.
    logic                  rvalid;    // Read data valid.
    logic [31:0]           rdata;     // Read data.
    logic [1:0]            rresp;     // Read response code.
    logic [FIELD_W-1:0]    lead;      // Write lead cycles.
    logic [FIELD_W-1:0]    active;    // Write active cycles.
    logic [FIELD_W-1:0]    trail;     // Write trail cycles.
    logic                  rdy_en;    // Ready sampling enable.
    logic                  rdy_mode;  // Ready sampling style.
    logic [ADDR_W-1:0]     wr_addr;   // Address for the next access.
    logic [DATA_W-1:0]     wr_data;   // Data for the next access.
    logic                  busy;      // An access is under way.
    logic                  req_tgl;   // Toggles once per request.
    logic [CNT_W-1:0]      wait_copy; // Wait states of the last access.
  } reg_state_t;

  //////////////////////////////////////////////////////////////////////////////
  // Link side state, clocked by the interface timing clock.

  typedef struct packed {
    phase_t                phase;     // Current access phase.
    logic                  co;        // Interface output clock.
    logic [CNT_W-1:0]      acc;       // Periods since the lead began.
    logic [FIELD_W-1:0]    tcnt;      // Periods spent in trail.
    logic                  rdy_seen;  // A sample already found ready.
    logic                  zone_n;    // Zone select, active low.
    logic                  we_n;      // Write strobe, active low.
    logic                  rnw;       // Read-not-write line.
    logic                  oe;        // Data bus drive enable.
    logic [ADDR_W-1:0]     addr_q;    // Address on the bus.
    logic [DATA_W-1:0]     data_q;    // Data on the bus.
    logic [FIELD_W-1:0]    lead;      // Captured lead length.
    logic [FIELD_W-1:0]    active;    // Captured active length.
    logic [FIELD_W-1:0]    trail;     // Captured trail length.
    logic                  rdy_en;    // Captured ready enable.
    logic                  rdy_mode;  // Captured sampling style.
    logic [CNT_W-1:0]      wait_cnt;  // Wait states of this access.
    logic                  ack_tgl;   // Toggles once per completion.
  } link_state_t;

  reg_state_t  rs;
  reg_state_t  next_rs;
  link_state_t ls;
  link_state_t next_ls;

  logic link_rst_n; // Reset brought into the link domain.
  logic rdy_sync;   // Ready pin after two flip-flops.
  logic start_evt;  // One pulse per request, link domain.
  logic done_evt;   // One pulse per completion, aclk domain.

  //////////////////////////////////////////////////////////////////////////////
  // Domain crossings.

  // Reset for the link domain, released in step with its clock.
  bit_sync2 u_rst_sync (
    .clk   (iface_timing_clock),
    .rst_n (1'b1),
    .d     (aresetn),
    .q     (link_rst_n)
  );

  // The ready pin passes two flip-flops before the sequencer reads it.
  bit_sync2 u_rdy_sync (
    .clk   (iface_timing_clock),
    .rst_n (link_rst_n),
    .d     (ext_ready_in),
    .q     (rdy_sync)
  );

  // Request toggle into the link domain.
  toggle_event u_req_evt (
    .clk    (iface_timing_clock),
    .rst_n  (link_rst_n),
    .tgl_in (rs.req_tgl),
    .pulse  (start_evt)
  );

  // Completion toggle back into the register domain.
  toggle_event u_ack_evt (
    .clk    (aclk),
    .rst_n  (aresetn),
    .tgl_in (ls.ack_tgl),
    .pulse  (done_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register side.

  // Merges bytes of a write word into an old value by byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // AXI4-Lite slave: channel handshakes, decode and access launch.
  always_comb begin
    logic [31:0] cfg;
    logic [31:0] word;
    cfg = '0;
    word = '0;
    next_rs = rs;
    cfg[LEAD_POS +: FIELD_W] = rs.lead;
    cfg[ACTIVE_POS +: FIELD_W] = rs.active;
    cfg[TRAIL_POS +: FIELD_W] = rs.trail;
    cfg[READY_EN_POS] = rs.rdy_en;
    cfg[READY_MODE_POS] = rs.rdy_mode;
    // Take the address and data channels in either order.
    if (s_axi_awvalid && rs.awready) begin
      next_rs.aw_full = 1'b1;
      next_rs.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && rs.wready) begin
      next_rs.w_full = 1'b1;
      next_rs.w_data = s_axi_wdata;
      next_rs.w_strb = s_axi_wstrb;
    end
    // A finished access frees the block for the next one.
    if (done_evt) begin
      next_rs.busy = 1'b0;
      next_rs.wait_copy = ls.wait_cnt;
    end
    // Perform a write once both halves are held.
    if (rs.aw_full && rs.w_full && !rs.bvalid) begin
      next_rs.aw_full = 1'b0;
      next_rs.w_full = 1'b0;
      next_rs.bvalid = 1'b1;
      next_rs.bresp = RESP_OKAY;
      if (rs.aw_addr == ZONE_TIMING_CONFIG_OFS) begin
        // Timing is frozen while an access runs.
        if (rs.busy) begin
          next_rs.bresp = RESP_SLVERR;
        end else begin
          word = merge(cfg, rs.w_data, rs.w_strb);
          next_rs.lead = word[LEAD_POS +: FIELD_W];
          next_rs.active = word[ACTIVE_POS +: FIELD_W];
          next_rs.trail = word[TRAIL_POS +: FIELD_W];
          next_rs.rdy_en = word[READY_EN_POS];
          next_rs.rdy_mode = word[READY_MODE_POS];
        end
      end else if (rs.aw_addr == WRITE_ADDR_OFS) begin
        // The address is frozen while an access runs.
        if (rs.busy) begin
          next_rs.bresp = RESP_SLVERR;
        end else begin
          word = merge({13'h0, rs.wr_addr}, rs.w_data, rs.w_strb);
          next_rs.wr_addr = word[ADDR_W-1:0];
        end
      end else if (rs.aw_addr == WRITE_DATA_OFS) begin
        // Writing the data word launches one external access.
        if (rs.busy) begin
          next_rs.bresp = RESP_SLVERR;
        end else begin
          word = merge({16'h0, rs.wr_data}, rs.w_data, rs.w_strb);
          next_rs.wr_data = word[DATA_W-1:0];
          next_rs.busy = 1'b1;
          next_rs.req_tgl = ~rs.req_tgl;
        end
      end else if (rs.aw_addr != STATUS_OFS) begin
        // Unmapped addresses answer with an error.
        next_rs.bresp = RESP_SLVERR;
      end
    end
    // Retire the write response.
    if (rs.bvalid && s_axi_bready) begin
      next_rs.bvalid = 1'b0;
    end
    // Answer a read one cycle after its address is taken.
    if (s_axi_arvalid && rs.arready) begin
      next_rs.rvalid = 1'b1;
      next_rs.rresp = RESP_OKAY;
      next_rs.rdata = '0;
      if (s_axi_araddr == ZONE_TIMING_CONFIG_OFS) begin
        next_rs.rdata = cfg;
      end else if (s_axi_araddr == WRITE_ADDR_OFS) begin
        next_rs.rdata = {13'h0, rs.wr_addr};
      end else if (s_axi_araddr == WRITE_DATA_OFS) begin
        next_rs.rdata = {16'h0, rs.wr_data};
      end else if (s_axi_araddr == STATUS_OFS) begin
        next_rs.rdata[BUSY_POS] = rs.busy;
        next_rs.rdata[WAIT_POS +: CNT_W] = rs.wait_copy;
      end else begin
        next_rs.rresp = RESP_SLVERR;
      end
    end else if (rs.rvalid && s_axi_rready) begin
      next_rs.rvalid = 1'b0;
    end
    // Each channel is ready only while it has room.
    next_rs.awready = !next_rs.aw_full;
    next_rs.wready = !next_rs.w_full;
    next_rs.arready = !next_rs.rvalid;
  end

  // Register side flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs <= '0;
      rs.awready <= 1'b1;
      rs.wready <= 1'b1;
      rs.arready <= 1'b1;
      rs.lead <= LEAD_RESET;
      rs.active <= ACTIVE_RESET;
      rs.trail <= TRAIL_RESET;
      rs.rdy_en <= READY_EN_RESET;
      rs.rdy_mode <= READY_MODE_RESET;
    end else begin
      rs <= next_rs;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link side sequencer.

  // Walks one write through align, lead, active and trail.
  always_comb begin
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] lead_e;
    logic [CNT_W-1:0] sum;
    logic [CNT_W-1:0] samp_pt;
    logic [FIELD_W-1:0] trail_e;
    logic seen;
    // Saturate so a very long stall cannot wrap the count back to zero.
    elapsed = (ls.acc == '1) ? ls.acc : ls.acc + 16'h0001;
    // A zero lead or trail field still takes one period.
    lead_e = (ls.lead == '0) ? 16'h0001 : {13'h0, ls.lead};
    trail_e = (ls.trail == '0) ? 3'h1 : ls.trail;
    sum = lead_e + {13'h0, ls.active};
    // The synchronised first sample sits at lead plus active.
    samp_pt = sum;
    if (ls.rdy_mode == READY_ASYNC) begin
      // The asynchronous first sample comes two periods earlier.
      samp_pt = (sum > ASYNC_EARLY_CYCLES) ?
                sum - ASYNC_EARLY_CYCLES : 16'h0001;
    end
    seen = ls.rdy_seen;
    next_ls = ls;
    // The output clock runs at half the timing clock.
    next_ls.co = ~ls.co;
    unique case (ls.phase)
      PH_IDLE: begin
        if (start_evt) begin
          // Take the quasi-static request words, stable while busy.
          next_ls.lead = rs.lead;
          next_ls.active = rs.active;
          next_ls.trail = rs.trail;
          next_ls.rdy_en = rs.rdy_en;
          next_ls.rdy_mode = rs.rdy_mode;
          next_ls.data_q = rs.wr_data;
          next_ls.acc = '0;
          next_ls.rdy_seen = 1'b0;
          next_ls.wait_cnt = '0;
          if (!ls.co) begin
            // Output clock rises on this edge, so the lead may start.
            next_ls.phase = PH_LEAD;
            next_ls.addr_q = rs.wr_addr;
            next_ls.zone_n = 1'b0;
            next_ls.rnw = 1'b0;
          end else begin
            // Wrong phase: spend one alignment period first.
            next_ls.phase = PH_ALIGN;
          end
        end
      end
      PH_ALIGN: begin
        // Strobes stay inactive for this period; the address is loaded as it ends.
        next_ls.zone_n = 1'b1;
        next_ls.we_n = 1'b1;
        next_ls.rnw = 1'b1;
        // The output clock is low now and rises on this edge.
        next_ls.phase = PH_LEAD;
        next_ls.addr_q = rs.wr_addr;
        next_ls.zone_n = 1'b0;
        next_ls.rnw = 1'b0;
      end
      PH_LEAD: begin
        next_ls.acc = elapsed;
        if (elapsed >= lead_e) begin
          // The strobe and the data drive start together.
          next_ls.phase = PH_ACTIVE;
          next_ls.we_n = 1'b0;
          next_ls.oe = 1'b1;
        end
      end
      PH_ACTIVE: begin
        if (ls.acc != '1) begin
          next_ls.acc = elapsed;
        end
        // Sample ready once per period from the first sample point.
        if (ls.rdy_en && elapsed >= samp_pt && rdy_sync) begin
          seen = 1'b1;
        end
        next_ls.rdy_seen = seen;
        if (elapsed >= sum) begin
          // With sampling off the ready pin is ignored.
          if (!ls.rdy_en || seen) begin
            next_ls.phase = PH_TRAIL;
            next_ls.we_n = 1'b1;
            next_ls.tcnt = '0;
          end else if (ls.wait_cnt != '1) begin
            // A low sample stalls the write for one more period.
            next_ls.wait_cnt = ls.wait_cnt + 16'h0001;
          end
        end
      end
      PH_TRAIL: begin
        // Data stays driven and unchanged through the trail.
        next_ls.tcnt = ls.tcnt + 3'h1;
        if (ls.tcnt + 3'h1 >= trail_e) begin
          // Drive ends on the edge that raises read-not-write.
          next_ls.phase = PH_IDLE;
          next_ls.zone_n = 1'b1;
          next_ls.rnw = 1'b1;
          next_ls.oe = 1'b0;
          next_ls.ack_tgl = ~ls.ack_tgl;
        end
      end
    endcase
  end

  // Link side flip-flops; the address is kept between accesses.
  always_ff @(posedge iface_timing_clock) begin
    if (!link_rst_n) begin
      ls <= '0;
      ls.phase <= PH_IDLE;
      ls.zone_n <= 1'b1;
      ls.we_n <= 1'b1;
      ls.rnw <= 1'b1;
      ls.lead <= LEAD_RESET;
      ls.active <= ACTIVE_RESET;
      ls.trail <= TRAIL_RESET;
    end else begin
      ls <= next_ls;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.

  assign s_axi_awready = rs.awready;
  assign s_axi_wready = rs.wready;
  assign s_axi_bvalid = rs.bvalid;
  assign s_axi_bresp = rs.bresp;
  assign s_axi_arready = rs.arready;
  assign s_axi_rvalid = rs.rvalid;
  assign s_axi_rdata = rs.rdata;
  assign s_axi_rresp = rs.rresp;
  assign iface_clock_out = ls.co;
  assign zone_select_n = ls.zone_n;
  assign write_strobe_n = ls.we_n;
  assign read_not_write = ls.rnw;
  assign addr_out = ls.addr_q;
  assign data_out = ls.data_q;
  assign data_oe = ls.oe;

endmodule : ext_bus_write_ready_wait

`default_nettype wire

// [ext_bus_write_ready_wait_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the external bus pins in the link clock domain.
module ext_bus_write_checker
  import ext_bus_write_pkg::*;
(
  input wire logic              aresetn,
  input wire logic              iface_timing_clock,
  input wire logic              iface_clock_out,
  input wire logic              zone_select_n,
  input wire logic              write_strobe_n,
  input wire logic              read_not_write,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe
);
  default clocking cb @(posedge iface_timing_clock); endclocking
  default disable iff (!aresetn);
  // An access starts where the zone select falls.
  sequence s_lead; $fell(zone_select_n); endsequence
  // The active phase ends where the write strobe rises.
  sequence s_we_end; $rose(write_strobe_n); endsequence
  property p_lead_rise; s_lead |-> $rose(iface_clock_out); endproperty
  a_lead_rise: assert property (p_lead_rise)
    else $error("lead began off a clock rise");
  property p_we_zone; !write_strobe_n |-> !zone_select_n; endproperty
  a_we_zone: assert property (p_we_zone)
    else $error("write strobe outside the access");
  property p_addr_hold;
    zone_select_n && $past(zone_select_n) |-> $stable(addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved while idle");
  property p_oe_start; $rose(data_oe) == $fell(write_strobe_n); endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("data drive not with strobe");
  property p_trail; s_we_end |-> data_oe && $stable(data_out); endproperty
  a_trail: assert property (p_trail)
    else $error("data lost at strobe end");
  property p_data_hold; data_oe && $past(data_oe) |-> $stable(data_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data changed while driven");
  property p_release;
    $rose(read_not_write) |-> $fell(data_oe) && $rose(zone_select_n);
  endproperty
  a_release: assert property (p_release)
    else $error("data bus not released");
  property p_rnw_zone; read_not_write == zone_select_n; endproperty
  a_rnw_zone: assert property (p_rnw_zone)
    else $error("direction line apart from zone");
endmodule : ext_bus_write_checker
bind ext_bus_write_ready_wait ext_bus_write_checker chk_u (.*);
`default_nettype wire

// [ext_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// External memory that adds wait states and records each write.
module ext_mem_model
  import ext_bus_write_pkg::*;
(
  input  wire logic              iface_timing_clock,
  input  wire logic              zone_select_n,
  input  wire logic              write_strobe_n,
  input  wire logic              data_oe,
  input  wire logic [ADDR_W-1:0] addr_out,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic [7:0]        dly,
  input  wire logic              early,
  output logic                   ext_ready_in,
  output logic [ADDR_W-1:0]      cap_addr,
  output logic [DATA_W-1:0]      cap_data,
  output logic [7:0]             zlen,
  output logic [7:0]             wlen
);
  logic [7:0] cnt    = 8'h00; // Periods since the zone select fell.
  logic       zone_q = 1'b1;  // Zone select one edge ago.
  logic       we_q   = 1'b1;  // Write strobe one edge ago.
  // Ready stays low for dly periods, with an optional first-period pulse.
  assign ext_ready_in = !zone_select_n &&
    (cnt >= dly || (early && cnt == 8'h00));
  // Measures phase lengths and takes the data after the strobe ends.
  always @(posedge iface_timing_clock) begin
    zone_q <= zone_select_n;
    we_q <= write_strobe_n;
    cnt <= zone_select_n ? 8'h00 : cnt + 8'h01;
    if (!zone_select_n) zlen <= zone_q ? 8'h01 : zlen + 8'h01;
    if (!zone_select_n && zone_q) wlen <= 8'h00;
    else if (!write_strobe_n) wlen <= wlen + 8'h01;
    // A released bus records inverted data, so a short hold shows.
    if (write_strobe_n && !we_q) begin
      cap_addr <= addr_out;
      cap_data <= data_oe ? data_out : ~data_out;
    end
  end
endmodule : ext_mem_model
`default_nettype wire

// [ext_bus_write_ready_wait_test.sv]
`timescale 1ns/1ps
`default_nettype none
// Runs one write access per table row and checks pins and status.
module ext_bus_write_ready_wait_test;
  import ext_bus_write_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, iface_timing_clock = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, early = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ext_ready_in, iface_clock_out, zone_select_n;
  logic write_strobe_n, read_not_write, data_oe;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [ADDR_W-1:0] addr_out, cap_addr;
  logic [DATA_W-1:0] data_out, cap_data;
  logic [7:0] zlen, wlen, dly = 8'h00;
  int err_total = 0, cmp_count = 0;
  // Rows: config word, ready delay, early pulse, expected wait states.
  logic [10:0] cfg_tab [7] = '{11'h059, 11'h259, 11'h259, 11'h659,
                                11'h659, 11'h2d2, 11'h008};
  logic [7:0] dly_tab [7] = '{8'h05, 8'h00, 8'h05, 8'h05, 8'h06, 8'h00, 8'h00};
  logic early_tab [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [7:0] wt_tab [7] = '{8'h0, 8'h0, 8'h4, 8'h0, 8'h5, 8'h0, 8'h0};
  always #10 aclk = ~aclk;
  // The link clock starts off phase with the register clock.
  initial begin
    #7;
    forever #40 iface_timing_clock = ~iface_timing_clock;
  end
  ext_bus_write_ready_wait dut_u (.*);
  ext_mem_model mem_u (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Register write with both channels offered together.
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Register read.
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Prints the verdict and ends the run.
  task automatic end_of_test;
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short.
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  // Main sequence; reset is held long enough for the link domain too.
  initial begin : main
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] lz, tz, ac;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ZONE_TIMING_CONFIG_OFS, d, r);
    chk("cfg reset", 32'h59, d);
    rd(32'h10, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    for (int i = 0; i < 7; i++) begin
      wr(ZONE_TIMING_CONFIG_OFS, {21'h0, cfg_tab[i]}, r);
      wr(WRITE_ADDR_OFS, 32'h40000 + 32'(i) * 32'h111, r);
      dly <= dly_tab[i];
      early <= early_tab[i];
      wr(WRITE_DATA_OFS, 32'h5a00 + 32'(i), r);
      wr(ZONE_TIMING_CONFIG_OFS, 32'h0, r);
      chk("busy resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      d = 32'h1;
      for (int k = 0; k < 100 && d[0] !== 1'b0; k++) rd(STATUS_OFS, d, r);
      chk("waits", {8'h0, wt_tab[i], 16'h0}, d);
      chk("addr", 32'h40000 + 32'(i) * 32'h111, {13'h0, cap_addr});
      chk("data", 32'h5a00 + 32'(i), {16'h0, cap_data});
      lz = (cfg_tab[i][2:0] == 3'h0) ? 8'h1 : {5'h0, cfg_tab[i][2:0]};
      tz = (cfg_tab[i][8:6] == 3'h0) ? 8'h1 : {5'h0, cfg_tab[i][8:6]};
      ac = {5'h0, cfg_tab[i][5:3]} + wt_tab[i];
      chk("zone len", {24'h0, lz + ac + tz}, {24'h0, zlen});
      chk("strobe len", {24'h0, ac}, {24'h0, wlen});
      rd(ZONE_TIMING_CONFIG_OFS, d, r);
      chk("cfg", {21'h0, cfg_tab[i]}, d);
    end
    end_of_test();
  end
endmodule : ext_bus_write_ready_wait_test
`default_nettype wire
